// ---- dv/tb_rasp_core.sv ----
`timescale 1ns/100ps
module tb_rasp_core;
  import rasp_pkg::*;

  // ************************************************************
  // Bench signals
  // ************************************************************
  localparam logic [15:0] KEY_A = 16'h00A5; // Arbitrary unlock keys
  localparam logic [15:0] KEY_B = 16'h005A;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic apre_tick = 1'b0;
  rasp_cal_t cal_now;
  logic second_tick;
  logic add_second_pulse;
  logic alarm_a_flag;
  logic init_mode;
  int bad_count = 0;
  int checked = 0;
  int n_sec = 0;
  int n_add = 0;
  logic [31:0] rv;

  rasp_core #(.KEY_FIRST(KEY_A), .KEY_SECOND(KEY_B)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .apre_tick(apre_tick), .cal_now(cal_now),
    .second_tick(second_tick), .add_second_pulse(add_second_pulse),
    .alarm_a_flag(alarm_a_flag), .init_mode(init_mode)
  );

  // Fixed calendar: 12:34:56 AM, day 27, weekday 3
  initial begin
    cal_now = '{pm: 1'b0, hour_tens_bcd: 2'h1, hour_units_bcd: 4'h2,
      minute_tens_bcd: 3'h3, minute_units_bcd: 4'h4,
      second_tens_bcd: 3'h5, second_units_bcd: 4'h6,
      day_tens_bcd: 2'h2, day_units_bcd: 4'h7, weekday: 3'h3};
  end

  // Free running clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // Count one-cycle pulses from the calendar side
  always @(posedge core_clk) begin
    if (second_tick === 1'b1) n_sec <= n_sec + 1;
    if (add_second_pulse === 1'b1) n_add <= n_add + 1;
  end

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask

  task automatic apre();
    @(posedge core_clk);
    apre_tick <= 1'b1;
    @(posedge core_clk);
    apre_tick <= 1'b0;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    rchk("alarm", ALARM_A_OFF, 32'h0000_0000);
    rchk("key", LOCK_KEY_OFF, 32'h0000_0000);
    rchk("fraction_counter_value", FRACTION_COUNTER_VALUE_OFF, 32'h0000_0000);
    rchk("shift", SHIFT_OFF, 32'h0000_0000);
    rchk("status", STATUS_OFF, 32'h0000_0006);
    rchk("reload", RELOAD_OFF, 32'h0000_00FF);
    rchk("unmapped", 8'h50, 32'h0000_0000);
  endtask

  // Writes while locked must leave no trace
  task automatic t_lock();
    wr(ALARM_A_OFF, 32'h1234_5678);
    rchk("alarm locked", ALARM_A_OFF, 32'h0000_0000);
    wr(SHIFT_OFF, 32'h0000_0004);
    rchk("shift locked", STATUS_OFF, 32'h0000_0006);
    wr(LOCK_KEY_OFF, {16'h0000, KEY_A});
    wr(LOCK_KEY_OFF, {16'h0000, KEY_B});
    rchk("key reads", LOCK_KEY_OFF, 32'h0000_0000);
    rchk("unlocked", STATUS_OFF, 32'h0000_0016);
    wr(ALARM_A_OFF, 32'hA712_34D6);
    rchk("alarm layout", ALARM_A_OFF, 32'hA712_34D6);
    wr(CTRL_OFF, 32'h0000_0002);
    wr(ALARM_A_OFF, 32'h0000_0000);
    rchk("alarm busy", ALARM_A_OFF, 32'hA712_34D6);
    wr(CTRL_OFF, 32'h0000_0003);
    #1 chk("init pin", 32'h1, {31'h0, init_mode});
    wr(ALARM_A_OFF, 32'h0000_0000);
    rchk("alarm init", ALARM_A_OFF, 32'h0000_0000);
  endtask

  // Reload of 3 gives one second per four prescaler ticks
  task automatic t_presc();
    logic [31:0] exp_cnt [5] = '{32'h3, 32'h2, 32'h1, 32'h0, 32'h3};
    wr(CTRL_OFF, 32'h0000_0001);
    wr(RELOAD_OFF, 32'h0000_0003);
    rchk("reload", RELOAD_OFF, 32'h0000_0003);
    apre();
    rchk("frozen", FRACTION_COUNTER_VALUE_OFF, 32'h0000_0000);
    chk("init ticks", 32'h0, n_sec);
    wr(CTRL_OFF, 32'h0000_0000);
    #1 chk("init pin", 32'h0, {31'h0, init_mode});
    for (int i = 0; i < 5; i++) begin
      apre();
      rchk("count", FRACTION_COUNTER_VALUE_OFF, exp_cnt[i]);
    end
    chk("seconds", 32'h2, n_sec);
  endtask

  task automatic t_shift();
    wr(SHIFT_OFF, 32'h0000_0002);
    rchk("pending", STATUS_OFF, 32'h0000_001C);
    wr(SHIFT_OFF, 32'h8000_0005);
    apre();
    rchk("shifted", FRACTION_COUNTER_VALUE_OFF, 32'h0000_0005);
    chk("no add", 32'h0, n_add);
    rchk("synced", STATUS_OFF, 32'h0000_0016);
    wr(SHIFT_OFF, 32'h8000_0001);
    rchk("shift reads", SHIFT_OFF, 32'h0000_0000);
    apre();
    repeat (3) @(posedge core_clk);
    chk("add pulse", 32'h1, n_add);
    rchk("shifted2", FRACTION_COUNTER_VALUE_OFF, 32'h0000_0006);
    // Software side waits for the shadows before trusting them
    rv = 32'h0000_0000;
    for (int i = 0; i < 8 && rv[ST_SYNCED_BIT] !== 1'b1; i++) begin
      rd(STATUS_OFF, rv);
    end
    chk("synced poll", 32'h1, {31'h0, rv[ST_SYNCED_BIT]});
  endtask

  // Apply one alarm pattern and wait for a calendar second
  task automatic t_case(input logic [31:0] v, input logic hit);
    int s;
    wr(CTRL_OFF, 32'h0000_0000);
    wr(ALARM_A_OFF, v);
    wr(CTRL_OFF, 32'h0000_0002);
    wr(STATUS_OFF, 32'h0000_0000);
    s = n_sec;
    for (int i = 0; i < 20 && n_sec == s; i++) begin
      apre();
      repeat (2) @(posedge core_clk);
    end
    repeat (2) @(posedge core_clk);
    #1 chk("alarm flag", {31'h0, hit}, {31'h0, alarm_a_flag});
  endtask

  task automatic t_alarm();
    t_case(32'h2712_3456, 1'b1);
    t_case(32'h2712_3457, 1'b0);
    t_case(32'h2712_34D7, 1'b1);
    t_case(32'h2712_3556, 1'b0);
    t_case(32'h2712_B556, 1'b1);
    t_case(32'h2713_3456, 1'b0);
    t_case(32'h2793_3456, 1'b1);
    t_case(32'h2752_3456, 1'b0);
    t_case(32'h2812_3456, 1'b0);
    t_case(32'hA812_3456, 1'b1);
    t_case(32'h7312_3456, 1'b1);
    t_case(32'h7412_3456, 1'b0);
    t_case(32'h2712_3456, 1'b1);
    rchk("flag sticky", STATUS_OFF, 32'h0000_0013);
    wr(STATUS_OFF, 32'h0000_0000);
    rchk("flag clear", STATUS_OFF, 32'h0000_0012);
    // Any key write while open relocks; a wrong second key too
    wr(LOCK_KEY_OFF, {16'h0000, KEY_A});
    rchk("relocked", STATUS_OFF, 32'h0000_0002);
    wr(SHIFT_OFF, 32'h0000_0001);
    rchk("shift refused", STATUS_OFF, 32'h0000_0002);
    wr(LOCK_KEY_OFF, {16'h0000, KEY_A});
    wr(LOCK_KEY_OFF, 32'h0000_1234);
    wr(LOCK_KEY_OFF, {16'h0000, KEY_B});
    rchk("bad key", STATUS_OFF, 32'h0000_0002);
  endtask

  // ************************************************************
  // Verdict, watchdog and main sequence
  // ************************************************************
  task automatic give_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_lock();
    t_presc();
    t_shift();
    t_alarm();
    give_verdict();
  end
endmodule // tb_rasp_core

// ---- rtl/rasp_core.sv ----
`timescale 1ns/100ps
module rasp_core import rasp_pkg::*; #(
  parameter logic [15:0] KEY_FIRST = 16'h00A5,
  parameter logic [15:0] KEY_SECOND = 16'h005A
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic apre_tick,
  input wire rasp_cal_t cal_now,
  output logic second_tick,
  output logic add_second_pulse,
  output logic alarm_a_flag,
  output logic init_mode
);

  // ************************************************************
  // State
  // ************************************************************
  rasp_alarm_t alarm_a;
  rasp_lock_t lock_state;
  logic [14:0] sync_prescaler_reload;
  logic [15:0] fraction_counter_value;
  logic [14:0] fraction_shift_value;
  logic add_one_second;
  logic shift_pending;
  logic shift_synced_flag;
  logic alarm_enable;
  logic tick_d;
  logic apply_d;
  logic unlocked;
  logic alarm_write_allowed_flag;
  logic alarm_wr_ok;
  logic shift_wr_ok;
  logic shift_apply;
  logic wr_alarm;
  logic wr_key;
  logic wr_shift;
  logic wr_ctrl;
  logic wr_status;
  logic wr_reload;
  logic sec_ok;
  logic min_ok;
  logic hour_ok;
  logic day_ok;
  logic alarm_hit;
  logic [31:0] next_rdata;

  // ************************************************************
  // Decode
  // ************************************************************
  // Write strobes per register
  assign wr_alarm = reg_wr && (reg_addr == ALARM_A_OFF);
  assign wr_key = reg_wr && (reg_addr == LOCK_KEY_OFF);
  assign wr_shift = reg_wr && (reg_addr == SHIFT_OFF);
  assign wr_ctrl = reg_wr && (reg_addr == CTRL_OFF);
  assign wr_status = reg_wr && (reg_addr == STATUS_OFF);
  assign wr_reload = reg_wr && (reg_addr == RELOAD_OFF);

  assign unlocked = (lock_state == LK_OPEN);
  // Alarm may only change while it is not armed or in init mode
  assign alarm_write_allowed_flag = !alarm_enable;
  assign alarm_wr_ok = wr_alarm && unlocked
    && (alarm_write_allowed_flag || init_mode);
  assign shift_wr_ok = wr_shift && unlocked && !shift_pending;
  // Shift lands on the next prescaler edge, frozen in init mode
  assign shift_apply = shift_pending && !apply_d && apre_tick && !init_mode;

  // ************************************************************
  // Write protection key
  // ************************************************************
  // Two correct keys in a row open; anything else relocks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_state <= LK_LOCKED;
    end else if (wr_key) begin
      unique case (lock_state)
        LK_LOCKED: begin
          lock_state <= (reg_wdata[15:0] == KEY_FIRST) ? LK_HALF : LK_LOCKED;
        end
        LK_HALF: begin
          lock_state <= (reg_wdata[15:0] == KEY_SECOND) ? LK_OPEN : LK_LOCKED;
        end
        LK_OPEN: begin
          lock_state <= LK_LOCKED;
        end
      endcase
    end
  end

  // ************************************************************
  // Control and prescaler reload
  // ************************************************************
  // Both protected by the key; reload only in init mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_mode <= 1'b0;
      alarm_enable <= 1'b0;
    end else if (wr_ctrl && unlocked) begin
      init_mode <= reg_wdata[CTRL_INIT_BIT];
      alarm_enable <= reg_wdata[CTRL_ALARM_EN_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prescaler_reload <= RELOAD_RESET;
    end else if (wr_reload && unlocked && init_mode) begin
      sync_prescaler_reload <= reg_wdata[14:0];
    end
  end

  // ************************************************************
  // Alarm A register
  // ************************************************************
  // Field layout is fixed by the packed struct
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_a <= rasp_alarm_t'(ALARM_RESET);
    end else if (alarm_wr_ok) begin
      alarm_a <= rasp_alarm_t'(reg_wdata);
    end
  end

  // ************************************************************
  // Synchronous prescaler down-counter
  // ************************************************************
  // A pending shift replaces one decrement, or the reload at zero, by an addition
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fraction_counter_value <= COUNT_RESET;
    end else if (apre_tick && !init_mode) begin
      if (shift_apply) begin
        fraction_counter_value <= 16'(fraction_counter_value
          + {1'b0, fraction_shift_value});
      end else if (fraction_counter_value == COUNT_RESET) begin
        fraction_counter_value <= {1'b0, sync_prescaler_reload};
      end else begin
        fraction_counter_value <= 16'(fraction_counter_value - COUNT_ONE);
      end
    end
  end

  // One-cycle calendar tick when the counter wraps
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      second_tick <= 1'b0;
      tick_d <= 1'b0;
    end else begin
      second_tick <= apre_tick && !init_mode && !shift_apply
        && (fraction_counter_value == COUNT_RESET);
      tick_d <= second_tick || add_second_pulse;
    end
  end

  // ************************************************************
  // Shift register
  // ************************************************************
  // Value is latched at write, used at the next prescaler edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fraction_shift_value <= 15'h0000;
      add_one_second <= 1'b0;
    end else if (shift_wr_ok) begin
      fraction_shift_value <= reg_wdata[14:0];
      add_one_second <= reg_wdata[SHIFT_ADD_BIT];
    end
  end

  // Pending holds until the shadow refresh cycle so no write races it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_pending <= 1'b0;
      apply_d <= 1'b0;
      add_second_pulse <= 1'b0;
    end else begin
      apply_d <= shift_apply;
      add_second_pulse <= shift_apply && add_one_second;
      if (shift_wr_ok) begin
        shift_pending <= 1'b1;
      end else if (apply_d) begin
        shift_pending <= 1'b0;
      end
    end
  end

  // Synced flag drops on the write, returns once shadows caught up
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_synced_flag <= 1'b1;
    end else if (apply_d) begin
      shift_synced_flag <= 1'b1;
    end else if (shift_wr_ok) begin
      shift_synced_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Alarm comparison
  // ************************************************************
  // Masked fields always match
  assign sec_ok = alarm_a.seconds_mask
    || ({alarm_a.second_tens_bcd, alarm_a.second_units_bcd}
        == {cal_now.second_tens_bcd, cal_now.second_units_bcd});
  assign min_ok = alarm_a.minutes_mask
    || ({alarm_a.minute_tens_bcd, alarm_a.minute_units_bcd}
        == {cal_now.minute_tens_bcd, cal_now.minute_units_bcd});
  assign hour_ok = alarm_a.hours_mask
    || ({alarm_a.am_pm_format, alarm_a.hour_tens_bcd,
         alarm_a.hour_units_bcd} == {cal_now.pm, cal_now.hour_tens_bcd,
         cal_now.hour_units_bcd});
  // Weekday mode ignores the tens digit
  assign day_ok = alarm_a.date_mask
    || (alarm_a.weekday_select
        ? (alarm_a.day_units_bcd == {1'b0, cal_now.weekday})
        : ({alarm_a.day_tens_bcd, alarm_a.day_units_bcd}
           == {cal_now.day_tens_bcd, cal_now.day_units_bcd}));
  assign alarm_hit = alarm_enable && tick_d
    && sec_ok && min_ok && hour_ok && day_ok;

  // Sticky flag; a hit in the clearing cycle wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_a_flag <= 1'b0;
    end else if (alarm_hit) begin
      alarm_a_flag <= 1'b1;
    end else if (wr_status && !reg_wdata[ST_ALARM_BIT]) begin
      alarm_a_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Write-only and unmapped words read as zero
  always_comb begin
    next_rdata = READ_ZERO;
    unique case (reg_addr)
      ALARM_A_OFF: next_rdata = alarm_a;
      FRACTION_COUNTER_VALUE_OFF: next_rdata = {16'h0000, fraction_counter_value};
      CTRL_OFF: begin
        next_rdata[CTRL_INIT_BIT] = init_mode;
        next_rdata[CTRL_ALARM_EN_BIT] = alarm_enable;
      end
      STATUS_OFF: begin
        next_rdata[ST_ALARM_BIT] = alarm_a_flag;
        next_rdata[ST_SYNCED_BIT] = shift_synced_flag;
        next_rdata[ST_ALLOWED_BIT] = alarm_write_allowed_flag;
        next_rdata[ST_PENDING_BIT] = shift_pending;
        next_rdata[ST_UNLOCKED_BIT] = unlocked;
      end
      RELOAD_OFF: next_rdata = {17'h0_0000, sync_prescaler_reload};
      default: next_rdata = READ_ZERO;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // Refused alarm writes leave no trace, accepted ones land whole
  alarm_wr_gate_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_alarm && !(unlocked && (alarm_write_allowed_flag || init_mode))
    |=> $stable(alarm_a))
    else $error("locked alarm write took effect");

  alarm_wr_take_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    alarm_wr_ok |=> alarm_a == rasp_alarm_t'($past(reg_wdata)))
    else $error("accepted alarm write lost");

  // A hit with a field unmasked means that field really matched
  sec_mask_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    alarm_hit && !alarm_a.seconds_mask
    |-> {cal_now.second_tens_bcd, cal_now.second_units_bcd}
      == {alarm_a.second_tens_bcd, alarm_a.second_units_bcd})
    else $error("alarm hit with seconds mismatch");

  min_mask_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    alarm_hit && !alarm_a.minutes_mask
    |-> {cal_now.minute_tens_bcd, cal_now.minute_units_bcd}
      == {alarm_a.minute_tens_bcd, alarm_a.minute_units_bcd})
    else $error("alarm hit with minutes mismatch");

  hour_mask_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    alarm_hit && !alarm_a.hours_mask
    |-> {cal_now.hour_tens_bcd, cal_now.hour_units_bcd}
      == {alarm_a.hour_tens_bcd, alarm_a.hour_units_bcd})
    else $error("alarm hit with hours mismatch");

  pm_match_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    alarm_hit && !alarm_a.hours_mask |-> cal_now.pm == alarm_a.am_pm_format)
    else $error("alarm hit with hour format mismatch");

  day_mask_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    alarm_hit && !alarm_a.date_mask && !alarm_a.weekday_select
    |-> {cal_now.day_tens_bcd, cal_now.day_units_bcd}
      == {alarm_a.day_tens_bcd, alarm_a.day_units_bcd})
    else $error("alarm hit with date mismatch");

  weekday_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    alarm_hit && !alarm_a.date_mask && alarm_a.weekday_select
    |-> alarm_a.day_units_bcd == {1'b0, cal_now.weekday})
    else $error("alarm hit with weekday mismatch");

  // Write-only words never leak what was written
  key_reads_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && (reg_addr == LOCK_KEY_OFF || reg_addr == SHIFT_OFF)
    |=> reg_rdata == READ_ZERO)
    else $error("write-only word read nonzero");

  shift_locked_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_shift && !unlocked && !shift_pending |=> !shift_pending)
    else $error("shift taken while locked");

  shift_busy_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_shift && shift_pending |=> $stable(fraction_shift_value))
    else $error("shift value changed while pending");

  shift_add_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    shift_apply |=> fraction_counter_value
      == 16'($past(fraction_counter_value) + {1'b0, fraction_shift_value}))
    else $error("shift not added to counter");

  // Synced flag low from the write until two cycles after the apply
  synced_drop_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    shift_wr_ok |=> shift_pending && !shift_synced_flag)
    else $error("synced flag kept after shift write");

  synced_cycle_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    shift_apply |=> !shift_synced_flag ##1 shift_synced_flag && !shift_pending)
    else $error("synced flag sequence broken");

  add_second_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    shift_apply && add_one_second |=> add_second_pulse ##1 !add_second_pulse)
    else $error("add one second not pulsed");

  add_pair_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    add_second_pulse |-> $past(shift_apply) && add_one_second)
    else $error("add one second without a shift");

  tick_wrap_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    apre_tick && !init_mode && !shift_apply
      && fraction_counter_value == COUNT_RESET
    |=> second_tick
      && fraction_counter_value == {1'b0, $past(sync_prescaler_reload)})
    else $error("tick or reload wrong");

  alarm_cause_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(alarm_a_flag) |-> $past(tick_d) && $past(alarm_enable))
    else $error("alarm flag rose without tick");

  fraction_counter_value_read_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == FRACTION_COUNTER_VALUE_OFF
    |=> reg_rdata[15:0] == $past(fraction_counter_value))
    else $error("subsecond view wrong");

endmodule // rasp_core

// ---- rtl/rasp_pkg.sv ----
// Notes on behaviour
// - Alarm writable only if allowed/init and unlocked
// - Seconds mask bit 7 drops seconds compare
// - Minutes mask bit 15 drops minutes compare
// - Hours mask bit 23 drops hours compare
// - Date mask bit 31 drops day compare
// - Weekday select bit 30 changes day meaning
// - Bit 22 is PM versus AM/24h
// - Seconds BCD 3:0, 6:4; minute units 11:8
// - Minute tens 14:12, hours 19:16, 21:20
// - Day units 27:24, day tens 29:28
// - Key field write-only, always reads zero
// - Subsecond view shows prescaler down-counter
// - Counter above reload means one second ahead
// - Shift register ignored while write-locked
// - Fraction shift write-only, ignored while pending
// - Shift value is added to down-counter
// - Shift write clears synced flag, later sets
// - Add-one-second bit 31 advances calendar, reads zero
// - Calendar tick divides prescaler by reload+1
package rasp_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ALARM_A_OFF = 8'h1C;
  localparam logic [7:0] LOCK_KEY_OFF = 8'h24;
  localparam logic [7:0] FRACTION_COUNTER_VALUE_OFF = 8'h28;
  localparam logic [7:0] SHIFT_OFF = 8'h2C;
  localparam logic [7:0] CTRL_OFF = 8'h40;
  localparam logic [7:0] STATUS_OFF = 8'h44;
  localparam logic [7:0] RELOAD_OFF = 8'h48;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_ALARM_EN_BIT = 1;
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_SYNCED_BIT = 1;
  localparam int ST_ALLOWED_BIT = 2;
  localparam int ST_PENDING_BIT = 3;
  localparam int ST_UNLOCKED_BIT = 4;
  localparam int SHIFT_ADD_BIT = 31;
  localparam logic [31:0] ALARM_RESET = 32'h0000_0000;
  localparam logic [14:0] RELOAD_RESET = 15'h00FF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Alarm A layout, most significant field first
  typedef struct packed {
    logic date_mask;
    logic weekday_select;
    logic [1:0] day_tens_bcd;
    logic [3:0] day_units_bcd;
    logic hours_mask;
    logic am_pm_format;
    logic [1:0] hour_tens_bcd;
    logic [3:0] hour_units_bcd;
    logic minutes_mask;
    logic [2:0] minute_tens_bcd;
    logic [3:0] minute_units_bcd;
    logic seconds_mask;
    logic [2:0] second_tens_bcd;
    logic [3:0] second_units_bcd;
  } rasp_alarm_t;

  // Live calendar values from the calendar counters
  typedef struct packed {
    logic pm;
    logic [1:0] hour_tens_bcd;
    logic [3:0] hour_units_bcd;
    logic [2:0] minute_tens_bcd;
    logic [3:0] minute_units_bcd;
    logic [2:0] second_tens_bcd;
    logic [3:0] second_units_bcd;
    logic [1:0] day_tens_bcd;
    logic [3:0] day_units_bcd;
    logic [2:0] weekday;
  } rasp_cal_t;

  typedef enum logic [1:0] {LK_LOCKED, LK_HALF, LK_OPEN} rasp_lock_t;

endpackage
